// ### rtl/mshf_pkg.sv
// constants, states and carrier types of the station address and group hash filter
package mshf_pkg;

    // apb address width and register index (byte address is four times the index)
    localparam int unsigned APB_AW            = 8;
    localparam logic [5:0]  IDX_ADDR_HIGH     = 6'h02;
    localparam logic [5:0]  IDX_ADDR_LOW      = 6'h03;
    localparam logic [5:0]  IDX_HASH_UPPER    = 6'h04;
    localparam logic [5:0]  IDX_HASH_LOWER    = 6'h05;
    localparam logic [5:0]  IDX_FILTER_CTRL   = 6'h0a;
    localparam logic [5:0]  IDX_FILTER_STATUS = 6'h0b;

    // reset values
    localparam logic [31:0] RST_ADDR_HIGH  = 32'h0000ffff;
    localparam logic [31:0] RST_ADDR_LOW   = 32'h0fffffff;
    localparam logic [31:0] RST_HASH       = 32'h00000000;
    localparam logic        RST_PASS_ALL   = 1'h0;

    // field positions
    localparam int unsigned ADDR_HIGH_W     = 16;
    localparam int unsigned CTRL_PASS_ALL   = 0;
    localparam int unsigned STAT_READY      = 0;
    localparam int unsigned STAT_LOADED     = 1;
    localparam int unsigned HASH_SEL_BIT    = 5;
    localparam int unsigned GROUP_BIT       = 0;

    // configuration memory byte addresses holding the station address
    localparam logic [7:0]  CFG_FIRST_BYTE  = 8'h01;
    localparam logic [7:0]  CFG_LAST_BYTE   = 8'h06;

    // destination address length in bytes, as a last position
    localparam logic [2:0]  LAST_DEST_POS   = 3'h5;

    // reflected ethernet crc
    localparam logic [31:0] CRC_INIT        = 32'hffffffff;
    localparam logic [31:0] CRC_POLY        = 32'hedb88320;

    // preload sequence, gray coded along wait, busy, ready
    typedef enum logic [1:0] {
        LD_WAIT  = 2'b00,
        LD_BUSY  = 2'b01,
        LD_READY = 2'b11
    } mshf_load_state_t;

    // one byte from the configuration memory loader
    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } mshf_cfg_byte_t;

    // one received byte of a frame
    typedef struct packed {
        logic       valid;
        logic       first;
        logic [7:0] data;
    } mshf_rx_byte_t;

    // filter verdict for one frame
    typedef struct packed {
        logic       valid;
        logic       unicast_match;
        logic       group;
        logic       accept;
        logic [5:0] hash_idx;
    } mshf_rx_result_t;

endpackage

// ### rtl/mshf_crc_hash.sv
// running crc over destination address bytes, giving the six-bit hash index
`timescale 1ns/1ps
module mshf_crc_hash (
    // clock, reset, enable
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    // byte stream
    input  wire logic        byte_valid_i,
    input  wire logic        byte_first_i,
    input  wire logic [7:0]  byte_data_i,
    // hash index of the bytes so far
    output logic      [5:0]  hash_idx_o
);

    logic [31:0] crc_reg;
    logic [31:0] crc_next;

    // one byte step of the reflected crc
    function automatic logic [31:0] crc_step(input logic [31:0] crc, input logic [7:0] b);
        logic [31:0] c;
        c = crc ^ {24'h000000, b};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ mshf_pkg::CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

    // a first byte restarts from the seed so equal addresses give equal indexes
    always_comb begin
        crc_next = crc_step(byte_first_i ? mshf_pkg::CRC_INIT : crc_reg, byte_data_i);
    end

    // crc register
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            crc_reg <= mshf_pkg::CRC_INIT;
        end else if (ce_i && byte_valid_i) begin
            crc_reg <= crc_next;
        end
    end

    assign hash_idx_o = crc_reg[5:0];

endmodule

// ### rtl/mshf_filter.sv
// station address registers, preload and group hash filter behind an apb slave
//
// Notes on behaviour
// - address bits 47:32 in high register, upper reserved
// - address bits 31:0 fill low register
// - preload only when programmed memory detected
// - memory bytes 5,6 to high bits 7:0,15:8
// - memory bytes 1..4 to low register lanes
// - received bytes match lanes in wire order
// - leftmost address byte is sent first
// - address undefined until preload finishes
// - host writes address only after initialisation
// - 64-bit table filters group destination addresses
// - index msb picks register, rest picks bit
// - 000000 low bit 0, 111111 high bit 31
// - table bit one accepts, zero rejects
// - pass all group frames overrides table
// - table bits 63:32 upper, 31:0 lower
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module mshf_filter (
    // clock, reset, enable
    input  wire logic                        sys_clk_i,
    input  wire logic                        rst_n_i,
    input  wire logic                        ce_i,
    // apb slave
    input  wire logic                        psel_i,
    input  wire logic                        penable_i,
    input  wire logic                        pwrite_i,
    input  wire logic [mshf_pkg::APB_AW-1:0] paddr_i,
    input  wire logic [31:0]                 pwdata_i,
    output logic      [31:0]                 prdata_o,
    output logic                             pready_o,
    output logic                             pslverr_o,
    // configuration memory loader
    input  wire logic                        cfg_present_i,
    input  wire logic                        cfg_done_i,
    input  wire mshf_pkg::mshf_cfg_byte_t    cfg_byte_i,
    // receive path
    input  wire mshf_pkg::mshf_rx_byte_t     rx_byte_i,
    output mshf_pkg::mshf_rx_result_t        rx_result_o
);

    // registers
    logic [31:0]                station_address_high_reg;
    logic [31:0]                station_address_low_reg;
    logic [31:0]                group_hash_upper_reg;
    logic [31:0]                group_hash_lower_reg;
    logic                       pass_all_group_frames_reg;
    logic                       loaded_reg;
    mshf_pkg::mshf_load_state_t load_state_reg;
    mshf_pkg::mshf_load_state_t load_state_next;
    // apb
    logic [31:0]                prdata_reg;
    logic                       pready_reg;
    logic                       pslverr_reg;
    logic                       apb_commit;
    logic                       reg_hit;
    logic                       wr_blocked;
    logic [5:0]                 reg_idx;
    // receive
    logic [2:0]                 dest_pos_reg;
    logic                       in_dest_reg;
    logic                       match_reg;
    logic                       group_reg;
    logic                       eval_reg;
    logic [5:0]                 hash_idx;
    logic                       dest_byte_ok;
    mshf_pkg::mshf_rx_result_t  rx_result_reg;

    // byte k of the 48-bit station address, k counted in wire order
    function automatic logic [7:0] addr_byte(input logic [31:0] hi, input logic [31:0] lo,
                                             input logic [2:0] k);
        logic [47:0] a;
        a = {hi[mshf_pkg::ADDR_HIGH_W-1:0], lo};
        return a[{k, 3'h0} +: 8];
    endfunction

    // table bit chosen by a six-bit index
    function automatic logic hash_bit(input logic [31:0] upper, input logic [31:0] lower,
                                      input logic [5:0] idx);
        return idx[mshf_pkg::HASH_SEL_BIT] ? upper[idx[4:0]] : lower[idx[4:0]];
    endfunction

    // ------------------------------------------------------------------
    // preload sequencing
    // ------------------------------------------------------------------

    // next preload state
    // load gated by detection
    always_comb begin
        load_state_next = load_state_reg;
        unique case (load_state_reg)
            mshf_pkg::LD_WAIT: begin
                if (cfg_present_i) begin
                    load_state_next = mshf_pkg::LD_BUSY;
                end else if (cfg_done_i) begin
                    load_state_next = mshf_pkg::LD_READY;
                end
            end
            mshf_pkg::LD_BUSY: begin
                if (cfg_done_i) begin
                    load_state_next = mshf_pkg::LD_READY;
                end
            end
            mshf_pkg::LD_READY: begin
                load_state_next = mshf_pkg::LD_READY;
            end
        endcase
    end

    // preload state register; reset restarts the preload
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            load_state_reg <= mshf_pkg::LD_WAIT;
        end else if (ce_i) begin
            load_state_reg <= load_state_next;
        end
    end

    // records that a preload really wrote the address
    // address valid only once loaded
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            loaded_reg <= 1'b0;
        end else if (ce_i && load_state_reg == mshf_pkg::LD_BUSY && cfg_done_i) begin
            loaded_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // apb slave, one wait state
    // ------------------------------------------------------------------

    // decode: aligned word, index in paddr[7:2]
    always_comb begin
        reg_idx    = paddr_i[mshf_pkg::APB_AW-1:2];
        reg_hit    = (paddr_i[1:0] == 2'h0) &&
                     (reg_idx == mshf_pkg::IDX_ADDR_HIGH   ||
                      reg_idx == mshf_pkg::IDX_ADDR_LOW    ||
                      reg_idx == mshf_pkg::IDX_HASH_UPPER  ||
                      reg_idx == mshf_pkg::IDX_HASH_LOWER  ||
                      reg_idx == mshf_pkg::IDX_FILTER_CTRL ||
                      reg_idx == mshf_pkg::IDX_FILTER_STATUS);
        // address writes refused before initialisation ends
        wr_blocked = pwrite_i && (load_state_reg != mshf_pkg::LD_READY) &&
                     (reg_idx == mshf_pkg::IDX_ADDR_HIGH || reg_idx == mshf_pkg::IDX_ADDR_LOW);
        apb_commit = psel_i && penable_i && pready_reg;
    end

    // ready, error and read data, prepared one cycle ahead of the commit edge
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h00000000;
        end else if (ce_i) begin
            if (psel_i && penable_i && !pready_reg) begin
                pready_reg  <= 1'b1;
                pslverr_reg <= !reg_hit || wr_blocked;
                prdata_reg  <= 32'h00000000;
                if (!pwrite_i && reg_hit) begin
                    unique case (reg_idx)
                        mshf_pkg::IDX_ADDR_HIGH:     prdata_reg <= station_address_high_reg;
                        mshf_pkg::IDX_ADDR_LOW:      prdata_reg <= station_address_low_reg;
                        mshf_pkg::IDX_HASH_UPPER:    prdata_reg <= group_hash_upper_reg;
                        mshf_pkg::IDX_HASH_LOWER:    prdata_reg <= group_hash_lower_reg;
                        mshf_pkg::IDX_FILTER_CTRL: begin
                            prdata_reg[mshf_pkg::CTRL_PASS_ALL] <= pass_all_group_frames_reg;
                        end
                        mshf_pkg::IDX_FILTER_STATUS: begin
                            prdata_reg[mshf_pkg::STAT_READY]  <=
                                (load_state_reg == mshf_pkg::LD_READY);
                            prdata_reg[mshf_pkg::STAT_LOADED] <= loaded_reg;
                        end
                        default: prdata_reg <= 32'h00000000;
                    endcase
                end
            end else begin
                pready_reg  <= 1'b0;
                pslverr_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // station address registers
    // ------------------------------------------------------------------

    // high register: preload bytes 5 and 6, or host writes after init
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            station_address_high_reg <= mshf_pkg::RST_ADDR_HIGH;
        end else if (ce_i) begin
            if (load_state_reg == mshf_pkg::LD_BUSY && cfg_byte_i.valid &&
                cfg_byte_i.addr >= mshf_pkg::CFG_FIRST_BYTE + 8'h04 &&
                cfg_byte_i.addr <= mshf_pkg::CFG_LAST_BYTE) begin
                station_address_high_reg[{cfg_byte_i.addr[0] ? 2'h0 : 2'h1, 3'h0} +: 8]
                    <= cfg_byte_i.data;
            end else if (apb_commit && pwrite_i && !pslverr_reg &&
                         reg_idx == mshf_pkg::IDX_ADDR_HIGH) begin
                station_address_high_reg <= {16'h0000, pwdata_i[mshf_pkg::ADDR_HIGH_W-1:0]};
            end
        end
    end

    // low register: preload bytes 1 to 4, or host writes after init
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            station_address_low_reg <= mshf_pkg::RST_ADDR_LOW;
        end else if (ce_i) begin
            if (load_state_reg == mshf_pkg::LD_BUSY && cfg_byte_i.valid &&
                cfg_byte_i.addr >= mshf_pkg::CFG_FIRST_BYTE &&
                cfg_byte_i.addr < mshf_pkg::CFG_FIRST_BYTE + 8'h04) begin
                station_address_low_reg[{cfg_byte_i.addr[1:0] - 2'h1, 3'h0} +: 8]
                    <= cfg_byte_i.data;
            end else if (apb_commit && pwrite_i && !pslverr_reg &&
                         reg_idx == mshf_pkg::IDX_ADDR_LOW) begin
                station_address_low_reg <= pwdata_i;
            end
        end
    end

    // hash table and pass-all control
    // upper and lower table halves
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            group_hash_upper_reg      <= mshf_pkg::RST_HASH;
            group_hash_lower_reg      <= mshf_pkg::RST_HASH;
            pass_all_group_frames_reg <= mshf_pkg::RST_PASS_ALL;
        end else if (ce_i && apb_commit && pwrite_i && !pslverr_reg) begin
            if (reg_idx == mshf_pkg::IDX_HASH_UPPER) begin
                group_hash_upper_reg <= pwdata_i;
            end
            if (reg_idx == mshf_pkg::IDX_HASH_LOWER) begin
                group_hash_lower_reg <= pwdata_i;
            end
            if (reg_idx == mshf_pkg::IDX_FILTER_CTRL) begin
                pass_all_group_frames_reg <= pwdata_i[mshf_pkg::CTRL_PASS_ALL];
            end
        end
    end

    // ------------------------------------------------------------------
    // receive path: destination compare and hash
    // ------------------------------------------------------------------

    mshf_crc_hash u_crc_hash (
        .sys_clk_i    (sys_clk_i),
        .rst_n_i      (rst_n_i),
        .ce_i         (ce_i),
        .byte_valid_i (rx_byte_i.valid && (rx_byte_i.first || in_dest_reg)),
        .byte_first_i (rx_byte_i.first),
        .byte_data_i  (rx_byte_i.data),
        .hash_idx_o   (hash_idx)
    );

    // byte position k meets lane k
    // first received byte is the leftmost
    always_comb begin
        dest_byte_ok = rx_byte_i.data ==
            addr_byte(station_address_high_reg, station_address_low_reg,
                      rx_byte_i.first ? 3'h0 : dest_pos_reg);
    end

    // walk the six destination bytes, accumulating the match
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            dest_pos_reg <= 3'h0;
            in_dest_reg  <= 1'b0;
            match_reg    <= 1'b0;
            group_reg    <= 1'b0;
            eval_reg     <= 1'b0;
        end else if (ce_i) begin
            eval_reg <= 1'b0;
            if (rx_byte_i.valid && (rx_byte_i.first || in_dest_reg)) begin
                if (rx_byte_i.first) begin
                    match_reg <= dest_byte_ok;
                    group_reg <= rx_byte_i.data[mshf_pkg::GROUP_BIT];
                end else begin
                    match_reg <= match_reg && dest_byte_ok;
                end
                if (!rx_byte_i.first && dest_pos_reg == mshf_pkg::LAST_DEST_POS) begin
                    in_dest_reg  <= 1'b0;
                    dest_pos_reg <= 3'h0;
                    eval_reg     <= 1'b1;
                end else begin
                    in_dest_reg  <= 1'b1;
                    dest_pos_reg <= rx_byte_i.first ? 3'h1 : dest_pos_reg + 3'h1;
                end
            end
        end
    end

    // verdict one cycle after the sixth byte
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rx_result_reg <= '0;
        end else if (ce_i) begin
            rx_result_reg.valid         <= eval_reg;
            rx_result_reg.unicast_match <= eval_reg && !group_reg && match_reg;
            rx_result_reg.group         <= eval_reg && group_reg;
            rx_result_reg.hash_idx      <= hash_idx;
            // index zero is lower bit 0
            rx_result_reg.accept <= eval_reg &&
                (group_reg ? (pass_all_group_frames_reg ||
                              hash_bit(group_hash_upper_reg, group_hash_lower_reg, hash_idx))
                           : match_reg);
        end
    end

    // outputs straight from flip-flops
    assign prdata_o    = prdata_reg;
    assign pready_o    = pready_reg;
    assign pslverr_o   = pslverr_reg;
    assign rx_result_o = rx_result_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    // table bit taken from a flat 64-bit view
    logic [63:0] hash_flat;
    assign hash_flat = {group_hash_upper_reg, group_hash_lower_reg};

    a_high_reserved_zero: assert property (
        station_address_high_reg[31:16] == 16'h0000)
        else $error("reserved half of high address register not zero");

    a_preload_high_lane: assert property (
        ce_i && load_state_reg == mshf_pkg::LD_BUSY && cfg_byte_i.valid &&
        cfg_byte_i.addr == mshf_pkg::CFG_LAST_BYTE
        |=> station_address_high_reg[15:8] == $past(cfg_byte_i.data))
        else $error("memory byte 6 not in high bits 15:8");

    a_preload_low_lane: assert property (
        ce_i && load_state_reg == mshf_pkg::LD_BUSY && cfg_byte_i.valid &&
        cfg_byte_i.addr == mshf_pkg::CFG_FIRST_BYTE
        |=> station_address_low_reg[7:0] == $past(cfg_byte_i.data))
        else $error("memory byte 1 not in low bits 7:0");

    a_no_load_absent: assert property (
        load_state_reg == mshf_pkg::LD_WAIT && !cfg_present_i
        |=> $stable(station_address_low_reg) && $stable(station_address_high_reg))
        else $error("address changed with no programmed memory");

    a_early_write_refused: assert property (
        ce_i && psel_i && penable_i && pwrite_i && !pready_o &&
        paddr_i == {mshf_pkg::IDX_ADDR_LOW, 2'h0} && load_state_reg == mshf_pkg::LD_WAIT
        |=> pready_o && pslverr_o)
        else $error("early address write not refused");

    a_host_write_low: assert property (
        ce_i && apb_commit && pwrite_i && !pslverr_reg && reg_idx == mshf_pkg::IDX_ADDR_LOW
        |=> station_address_low_reg == $past(pwdata_i))
        else $error("low address write lost");

    a_apb_one_wait: assert property (
        psel_i && penable_i && !pready_o && ce_i |=> pready_o ##1 !pready_o)
        else $error("apb answer not after one wait state");

    a_hash_select_bit: assert property (
        ce_i && eval_reg && group_reg && !pass_all_group_frames_reg
        |=> rx_result_o.accept == hash_flat[rx_result_o.hash_idx])
        else $error("group verdict differs from table bit");

    a_pass_all_group: assert property (
        ce_i && eval_reg && group_reg && pass_all_group_frames_reg
        |=> rx_result_o.valid && rx_result_o.accept)
        else $error("pass-all did not accept group frame");

endmodule

// ### verif/mshf_cfg_model.sv
// configuration memory loader model: presence, six address bytes, done
`timescale 1ns/1ps
module mshf_cfg_model #(
    parameter logic [47:0] MAC = 48'h123456789abc
) (
    // clock and reset
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_n_i,
    // control from the bench
    input  wire logic                 start_i,
    input  wire logic                 hold_i,
    input  wire logic                 absent_i,
    // loader side
    output logic                      cfg_present_o,
    output logic                      cfg_done_o,
    output mshf_pkg::mshf_cfg_byte_t  cfg_byte_o
);
    logic [3:0]  step_reg;
    logic [47:0] mac_reg;

    // presence first, then bytes 1..6 leftmost first, then done
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            step_reg <= 4'h0;
            mac_reg <= MAC;
            cfg_present_o <= 1'b0;
            cfg_done_o <= 1'b0;
            cfg_byte_o <= '0;
        end else if ((start_i || step_reg != 4'h0) && !hold_i) begin
            step_reg <= (step_reg == 4'h8) ? 4'h0 : step_reg + 4'h1;
            // an unprogrammed memory still streams bytes but never reports presence
            cfg_present_o <= !absent_i;
            cfg_done_o <= (step_reg == 4'h7);
            cfg_byte_o.valid <= (step_reg != 4'h0) && (step_reg < 4'h7);
            cfg_byte_o.addr <= {4'h0, step_reg};
            cfg_byte_o.data <= mac_reg[47:40];
            if (step_reg != 4'h0) begin
                mac_reg <= mac_reg << 8;
            end
        end else begin
            // idle or stalled: data lines no longer hold the last byte
            cfg_done_o <= 1'b0;
            cfg_byte_o.valid <= 1'b0;
            cfg_byte_o.data <= ~cfg_byte_o.data;
        end
    end
endmodule

// ### verif/mshf_filter_tb.sv
// self-checking bench: apb register access, preload and receive filtering
`timescale 1ns/1ps
module mshf_filter_tb;
    logic                      sys_clk_i, rst_n_i, psel, pen, pwr, pready, perr;
    logic                      start, hold, absent, present, done, e, ce;
    logic [7:0]                paddr;
    logic [31:0]               pwdata, prdata, d, a;
    logic [47:0]               da;
    logic [5:0]                h;
    mshf_pkg::mshf_cfg_byte_t  cfg;
    mshf_pkg::mshf_rx_byte_t   rx;
    mshf_pkg::mshf_rx_result_t r, res;
    int                        err_count = 0, num_checks = 0, n;

    mshf_filter uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr), .cfg_present_i(present),
        .cfg_done_i(done), .cfg_byte_i(cfg), .rx_byte_i(rx), .rx_result_o(res));
    mshf_cfg_model partner (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .start_i(start),
        .hold_i(hold), .absent_i(absent), .cfg_present_o(present), .cfg_done_o(done),
        .cfg_byte_o(cfg));

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        num_checks++;
        if (g !== x) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, g, x);
        end
    endtask

    // apb transfer: setup, access held until pready is sampled high
    task automatic acc(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        int k;
        k = 0;
        @(posedge sys_clk_i);
        {psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, w, ad, wd};
        @(posedge sys_clk_i);
        pen <= 1'b1;
        do begin
            @(posedge sys_clk_i);
            k++;
        end while (pready !== 1'b1 && k < 16);
        rd = prdata;
        er = perr;
        {psel, pen} <= 2'b00;
        if (k >= 16) err_count++;
    endtask

    task automatic rchk(input logic [7:0] ad, input logic [31:0] x);
        acc(1'b0, ad, 32'h0, d, e);
        chk(d, x);
        chk(e, 1'b0);
    endtask

    task automatic wtab(input logic [31:0] u, input logic [31:0] l);
        acc(1'b1, 8'h10, u, d, e);
        acc(1'b1, 8'h14, l, d, e);
    endtask

    // six destination bytes in wire order, then wait for the verdict pulse
    task automatic rx_frame(input logic [47:0] x);
        int k;
        for (k = 0; k < 6; k++) begin
            @(posedge sys_clk_i);
            rx <= {1'b1, k == 0, x[47 - 8 * k -: 8]};
        end
        @(posedge sys_clk_i);
        rx <= '0;
        k = 0;
        do begin
            @(posedge sys_clk_i);
            k++;
        end while (res.valid !== 1'b1 && k < 8);
        r = res;
        chk(r.valid, 1'b1);
    endtask

    // reflected crc, bytes lsb first, low six bits
    function automatic logic [5:0] hash6(input logic [47:0] x);
        logic [31:0] c;
        c = mshf_pkg::CRC_INIT;
        for (int i = 0; i < 48; i++) begin
            c = (c[0] ^ x[40 - 8 * (i / 8) + i % 8]) ? (c >> 1) ^ mshf_pkg::CRC_POLY : c >> 1;
        end
        return c[5:0];
    endfunction

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #40000;
        err_count++;
        results();
    end

    initial begin
        {rst_n_i, psel, pen, pwr, start, hold, absent} = '0;
        ce = 1'b1;
        {paddr, pwdata} = '0;
        rx = '0;
        repeat (2) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        rchk(8'h08, 32'h0000ffff);
        rchk(8'h10, 32'h0);
        rchk(8'h14, 32'h0);
        acc(1'b1, 8'h0c, 32'h1, d, e);
        chk(e, 1'b1);
        acc(1'b0, 8'h30, 32'h0, d, e);
        chk(e, 1'b1);
        $display("test reset done");
        // preload with the loader stalling midway
        start <= 1'b1;
        @(posedge sys_clk_i);
        start <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        hold <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        hold <= 1'b0;
        n = 0;
        do begin
            acc(1'b0, 8'h2c, 32'h0, d, e);
            n++;
        end while (d[0] !== 1'b1 && n < 20);
        chk(d, 32'h3);
        rchk(8'h0c, 32'h78563412);
        rchk(8'h08, 32'h0000bc9a);
        rx_frame(48'h123456789abc);
        chk(r.unicast_match, 1'b1);
        chk(r.accept, 1'b1);
        rx_frame(48'h123456789abd);
        chk(r.accept, 1'b0);
        acc(1'b1, 8'h08, 32'hffff1234, d, e);
        rchk(8'h08, 32'h00001234);
        rx_frame(48'h123456783412);
        chk(r.unicast_match, 1'b1);
        $display("test station address done");
        // table corners: index 0 in lower bit 0, index 3f in upper bit 31
        for (int i = 0; i < 2; i++) begin
            da = 48'h010000000000;
            while (hash6(da) !== {6{i[0]}}) da = da + 48'h1;
            a = i[0] ? 32'h80000000 : 32'h1;
            wtab(i[0] ? a : 32'h0, i[0] ? 32'h0 : a);
            rx_frame(da);
            chk(r.hash_idx, {6{i[0]}});
            chk(r.accept, 1'b1);
            wtab(i[0] ? 32'h0 : a, i[0] ? a : 32'h0);
            rx_frame(da);
            chk(r.accept, 1'b0);
        end
        wtab(32'h0, 32'h0);
        rx_frame(da);
        chk(r.accept, 1'b0);
        acc(1'b1, 8'h28, 32'h1, d, e);
        rx_frame(da);
        chk(r.group, 1'b1);
        chk(r.accept, 1'b1);
        $display("test group hash done");
        // enable dropped mid-access: the answer waits until it returns
        fork
            rchk(8'h2c, 32'h3);
            begin
                repeat (2) @(posedge sys_clk_i);
                ce <= 1'b0;
                repeat (3) @(posedge sys_clk_i);
                ce <= 1'b1;
            end
        join
        $display("test clock enable done");
        // second reset, memory not programmed: bytes stream but nothing loads
        rst_n_i <= 1'b0;
        absent <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        start <= 1'b1;
        @(posedge sys_clk_i);
        start <= 1'b0;
        repeat (12) @(posedge sys_clk_i);
        rchk(8'h2c, 32'h1);
        rchk(8'h0c, 32'h0fffffff);
        $display("test no memory done");
        results();
    end
endmodule
